/* File: nibble_tx_consts.vh */
`ifndef NIBBLE_TX_CONSTS_VH
`define NIBBLE_TX_CONSTS_VH
// register indices on the documented register port
`define REG_LOW_POWER_CONFIG_A 8'h15
`define REG_LOW_POWER_CONFIG_B 8'h16
`define REG_NIBBLE_LINK_CONFIG 8'h17
`define REG_USER_CONFIG_A 8'h18
`define REG_USER_CONFIG_B 8'h19
`define REG_FAULT_MASK_CONFIG 8'h1e
`define REG_USER_SCRATCH_WORD 8'h1f
`define REG_FAULT 8'h04
`define REG_SECOND_FAULT 8'h05
`define REG_CONTROL 8'h08
// fault register bit positions
`define FLT_SUPPLY_LOSS 0
`define FLT_WEAK_FIELD 1
`define FLT_INTERNAL 2
`define FLT_OVERTEMP 4
`define FLT_MEM_CORR 5
`define FLT_MEM_UNCORR 6
// second fault register bit positions
`define FLT2_RING_TEST 3
`define FLT2_LOGIC_TEST 4
// control register bits
`define CTRL_ERROR_CLEAR 0
`define CTRL_RING_TEST 1
`define CTRL_LOGIC_TEST 2
// link config fields
`define CFG_TICK_LSB 5
`define CFG_TICK_MSB 10
`define CFG_PAUSE 20
`define CFG_SERIAL 21
// low power config bit
`define LP_TURN_STEP 18
// nibble timing in ticks
`define LOW_TICKS 5
`define HIGH_BASE_TICKS 7
`define SYNC_LOW_TICKS 5
`define SYNC_TOTAL_TICKS 56
`define PAUSE_TOTAL_TICKS 12
`define DATA_NIBBLES 3
// self-test durations
`define CLK_HZ 50000000
`define LOGIC_TEST_MS 10
`define LOGIC_TEST_CYCLES ((`CLK_HZ / 1000) * `LOGIC_TEST_MS)
`define RING_STEPS 32
// reset values
`define FAULT_RESET 7'h01
`define CFG_RESET 24'h000000
`endif

/* File: sent_frame_tx.v */
`timescale 1ns/10ps
`include "nibble_tx_consts.vh"
// Contract
// - nibble length in ticks is low plus high; tick from configured tick period
// - value v sent as 5 low ticks then 7 plus v high ticks
// - frame order: sync, status nibble, data nibbles, crc, optional pause
// - status nibble holds status bits, or serial bits in their place when serial enabled
// - data nibbles carry unsigned 12-bit angle, full turn maps 0..4095
// - when pause configured, filler pause pulse follows crc before next frame
// - logic self-test completion records a fail flag in second fault register
// - logic self-test runs about 10 ms and sets flags on faults
// - host requests ring self-test per die; die enters that test
// - ring test steps each contact, stores angle per step, ends after revolution
// - signal path self-test faults set flags in second fault register
// - supply loss sets supply-loss fault flag
// - digital logic monitored; malfunction sets internal-fault flag
// - weak magnet sets weak-field flag
// - memory ecc single/double errors detected, single corrected, flags raised
// - while supply low, output word bit 2 driven high
// - temperature out of range sets overtemp flag
// - fault bits sticky until error clear command or reset
// - masked fault bit recorded but does not raise error flag
// - low power config bit 18 selects 45 or 180 degree turn step
module sent_frame_tx #(
    parameter LOGIC_TEST_CYCLES = `LOGIC_TEST_CYCLES,
    parameter RING_STEPS = `RING_STEPS
) (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // register port
    input wire [7:0] reg_addr,
    input wire [23:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [23:0] reg_rdata,
    // measurement and monitors
    input wire [11:0] angle,
    input wire [3:0] serial_bits,
    input wire supply_lost,
    input wire logic_fault,
    input wire field_weak,
    input wire mem_err_single,
    input wire mem_err_double,
    input wire supply_low,
    input wire temp_bad,
    input wire ring_test_bad,
    input wire logic_test_bad,
    input wire [11:0] ring_angle,
    // link and status outputs
    output reg sent_out,
    output reg error_flag,
    output reg [2:0] spi_status,
    output reg turn_step_45,
    output reg ring_busy,
    output reg [5:0] ring_contact,
    output reg ring_store,
    output reg [11:0] ring_store_angle
);
    ////////////////////////////////////////////////////////////////
    localparam S_SYNC = 6'b000001;
    localparam S_STAT = 6'b000010;
    localparam S_DATA = 6'b000100;
    localparam S_CRC = 6'b001000;
    localparam S_PAUSE = 6'b010000;
    localparam S_IDLE = 6'b100000;

    // standard nibble crc, polynomial x^4+x^3+x^2+1
    function [3:0] crc_step;
        input [3:0] c;
        input [3:0] d;
        reg [3:0] x;
        integer i;
        begin
            x = c ^ d;
            for (i = 0; i < 4; i = i + 1) begin
                x = x[3] ? ({x[2:0], 1'b0} ^ 4'hd) : {x[2:0], 1'b0};
            end
            crc_step = x;
        end
    endfunction

    // cut a tick count to the 6-bit pulse length counter on purpose
    function [5:0] ticks6;
        input integer n;
        begin
            ticks6 = n[5:0];
        end
    endfunction

    // whole pulse length of a value nibble; the low part never varies
    function [5:0] nib_total;
        input [3:0] v;
        begin
            nib_total = ticks6(`LOW_TICKS + `HIGH_BASE_TICKS + v);
        end
    endfunction

    reg [23:0] lp_a_reg, lp_b_reg, link_cfg_reg, user_a_reg, user_b_reg, mask_reg, scratch_reg;
    reg [6:0] fault_reg;
    reg [6:0] fault2_reg;
    reg [5:0] state_reg;
    reg [5:0] tick_cnt_reg;
    reg [5:0] tick_num_reg;
    reg [5:0] total_reg;
    reg [1:0] nib_idx_reg;
    reg [11:0] frame_angle_reg;
    reg [3:0] crc_reg;
    reg [3:0] cur_nib;
    reg [23:0] logic_cnt_reg;
    reg logic_run_reg;
    reg [2:0] sl_sync_reg, lf_sync_reg, fw_sync_reg, ms_sync_reg, md_sync_reg, lo_sync_reg, tb_sync_reg;
    wire [5:0] tick_len = link_cfg_reg[`CFG_TICK_MSB:`CFG_TICK_LSB];
    wire clr = reg_wr && reg_addr == `REG_CONTROL && reg_wdata[`CTRL_ERROR_CLEAR];

    ////////////////////////////////////////////////////////////////
    // three-flop pin synchronisers; stage 2 and 3 agreeing counts
    always @(posedge mclk) begin
        if (!rstn) begin
            sl_sync_reg <= 3'h0;
            lf_sync_reg <= 3'h0;
            fw_sync_reg <= 3'h0;
            ms_sync_reg <= 3'h0;
            md_sync_reg <= 3'h0;
            lo_sync_reg <= 3'h0;
            tb_sync_reg <= 3'h0;
        end else begin
            sl_sync_reg <= {sl_sync_reg[1:0], supply_lost};
            lf_sync_reg <= {lf_sync_reg[1:0], logic_fault};
            fw_sync_reg <= {fw_sync_reg[1:0], field_weak};
            ms_sync_reg <= {ms_sync_reg[1:0], mem_err_single};
            md_sync_reg <= {md_sync_reg[1:0], mem_err_double};
            lo_sync_reg <= {lo_sync_reg[1:0], supply_low};
            tb_sync_reg <= {tb_sync_reg[1:0], temp_bad};
        end
    end
    wire sl_ok = sl_sync_reg[1] & sl_sync_reg[2];
    wire lf_ok = lf_sync_reg[1] & lf_sync_reg[2];
    wire fw_ok = fw_sync_reg[1] & fw_sync_reg[2];
    wire ms_ok = ms_sync_reg[1] & ms_sync_reg[2];
    wire md_ok = md_sync_reg[1] & md_sync_reg[2];
    wire tb_ok = tb_sync_reg[1] & tb_sync_reg[2];

    ////////////////////////////////////////////////////////////////
    // config registers and readback
    always @(posedge mclk) begin
        if (!rstn) begin
            lp_a_reg <= `CFG_RESET;
            lp_b_reg <= `CFG_RESET;
            link_cfg_reg <= `CFG_RESET;
            user_a_reg <= `CFG_RESET;
            user_b_reg <= `CFG_RESET;
            mask_reg <= `CFG_RESET;
            scratch_reg <= `CFG_RESET;
            reg_rdata <= 24'h000000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `REG_LOW_POWER_CONFIG_A: lp_a_reg <= reg_wdata;
                    `REG_LOW_POWER_CONFIG_B: lp_b_reg <= reg_wdata;
                    `REG_NIBBLE_LINK_CONFIG: link_cfg_reg <= reg_wdata;
                    `REG_USER_CONFIG_A: user_a_reg <= reg_wdata;
                    `REG_USER_CONFIG_B: user_b_reg <= reg_wdata;
                    `REG_FAULT_MASK_CONFIG: mask_reg <= reg_wdata;
                    `REG_USER_SCRATCH_WORD: scratch_reg <= reg_wdata;
                    default: ;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `REG_LOW_POWER_CONFIG_A: reg_rdata <= lp_a_reg;
                    `REG_LOW_POWER_CONFIG_B: reg_rdata <= lp_b_reg;
                    `REG_NIBBLE_LINK_CONFIG: reg_rdata <= link_cfg_reg;
                    `REG_USER_CONFIG_A: reg_rdata <= user_a_reg;
                    `REG_USER_CONFIG_B: reg_rdata <= user_b_reg;
                    `REG_FAULT_MASK_CONFIG: reg_rdata <= mask_reg;
                    `REG_USER_SCRATCH_WORD: reg_rdata <= scratch_reg;
                    `REG_FAULT: reg_rdata <= {17'h00000, fault_reg};
                    `REG_SECOND_FAULT: reg_rdata <= {17'h00000, fault2_reg};
                    `REG_CONTROL: reg_rdata <= {21'h000000, logic_run_reg, ring_busy, 1'b0};
                    default: reg_rdata <= 24'h000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sticky fault flags; a new event wins over a clear in the same cycle
    always @(posedge mclk) begin
        if (!rstn) begin
            fault_reg <= `FAULT_RESET;
            fault2_reg <= 7'h00;
            error_flag <= 1'b0;
            spi_status <= 3'h0;
            turn_step_45 <= 1'b0;
        end else begin
            fault_reg <= (clr ? 7'h00 : fault_reg) | {
                md_ok,
                ms_ok,
                tb_ok,
                1'b0,
                lf_ok,
                fw_ok,
                sl_ok};
            fault2_reg <= (clr ? 7'h00 : fault2_reg) | {2'b00,
                logic_run_reg && logic_cnt_reg == 24'h000001 && logic_test_bad,
                ring_busy && ring_test_bad, 3'b000};
            // masked bits still stored but kept off the error flag
            error_flag <= |(fault_reg & ~mask_reg[6:0]) | |fault2_reg;
            // level flag, so it only moves once stages 2 and 3 agree
            if (lo_sync_reg[1] == lo_sync_reg[2])
                spi_status <= {lo_sync_reg[2], 2'b00};
            turn_step_45 <= lp_a_reg[`LP_TURN_STEP];
        end
    end

    ////////////////////////////////////////////////////////////////
    // logic self-test timer and ring self-test stepping
    always @(posedge mclk) begin
        if (!rstn) begin
            logic_run_reg <= 1'b0;
            logic_cnt_reg <= 24'h000000;
            ring_busy <= 1'b0;
            ring_contact <= 6'h00;
            ring_store <= 1'b0;
            ring_store_angle <= 12'h000;
        end else begin
            ring_store <= 1'b0;
            if (!logic_run_reg && reg_wr && reg_addr == `REG_CONTROL && reg_wdata[`CTRL_LOGIC_TEST]) begin
                logic_run_reg <= 1'b1;
                logic_cnt_reg <= LOGIC_TEST_CYCLES[23:0];
            end else if (logic_run_reg) begin
                logic_cnt_reg <= logic_cnt_reg - 24'h000001;
                if (logic_cnt_reg == 24'h000001)
                    logic_run_reg <= 1'b0;
            end
            if (!ring_busy && reg_wr && reg_addr == `REG_CONTROL && reg_wdata[`CTRL_RING_TEST]) begin
                ring_busy <= 1'b1;
                ring_contact <= 6'h00;
            end else if (ring_busy) begin
                ring_store <= 1'b1;
                ring_store_angle <= ring_angle;
                if (ring_contact == RING_STEPS[5:0] - 6'h01)
                    ring_busy <= 1'b0;
                else
                    ring_contact <= ring_contact + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // nibble value of the current slot
    always @* begin
        case (state_reg)
            S_STAT: cur_nib = link_cfg_reg[`CFG_SERIAL] ? serial_bits : {2'b00, |fault2_reg, error_flag};
            S_DATA: cur_nib = nib_idx_reg == 2'd0 ? frame_angle_reg[11:8] :
                              nib_idx_reg == 2'd1 ? frame_angle_reg[7:4] : frame_angle_reg[3:0];
            S_CRC: cur_nib = crc_reg;
            default: cur_nib = 4'h0;
        endcase
    end

    // tick divider and frame sequencer; line idles high
    always @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            tick_cnt_reg <= 6'h00;
            tick_num_reg <= 6'h00;
            total_reg <= 6'h00;
            nib_idx_reg <= 2'd0;
            frame_angle_reg <= 12'h000;
            crc_reg <= 4'h5;
            sent_out <= 1'b1;
        end else if (state_reg == S_IDLE) begin
            state_reg <= S_SYNC;
            total_reg <= ticks6(`SYNC_TOTAL_TICKS);
            tick_num_reg <= 6'h00;
            tick_cnt_reg <= 6'h00;
            frame_angle_reg <= angle;
            crc_reg <= 4'h5;
            sent_out <= 1'b0;
        end else if (tick_cnt_reg + 6'h01 < (tick_len == 6'h00 ? 6'h01 : tick_len)) begin
            tick_cnt_reg <= tick_cnt_reg + 6'h01;
        end else begin
            tick_cnt_reg <= 6'h00;
            if (tick_num_reg + 6'h01 < total_reg) begin
                tick_num_reg <= tick_num_reg + 6'h01;
                sent_out <= (tick_num_reg + 6'h01 >= `LOW_TICKS);
            end else begin
                tick_num_reg <= 6'h00;
                sent_out <= 1'b0;
                case (state_reg)
                    S_SYNC: begin
                        state_reg <= S_STAT;
                        total_reg <= nib_total(link_cfg_reg[`CFG_SERIAL] ? serial_bits :
                            {2'b00, |fault2_reg, error_flag});
                    end
                    S_STAT: begin
                        state_reg <= S_DATA;
                        nib_idx_reg <= 2'd0;
                        total_reg <= nib_total(frame_angle_reg[11:8]);
                    end
                    S_DATA: begin
                        crc_reg <= crc_step(crc_reg, cur_nib);
                        if (nib_idx_reg == `DATA_NIBBLES - 1) begin
                            state_reg <= S_CRC;
                            total_reg <= nib_total(crc_step(crc_reg, cur_nib));
                        end else begin
                            nib_idx_reg <= nib_idx_reg + 2'd1;
                            total_reg <= nib_total(nib_idx_reg == 2'd0 ? frame_angle_reg[7:4] : frame_angle_reg[3:0]);
                        end
                    end
                    S_CRC: begin
                        if (link_cfg_reg[`CFG_PAUSE]) begin
                            state_reg <= S_PAUSE;
                            total_reg <= ticks6(`PAUSE_TOTAL_TICKS);
                        end else begin
                            state_reg <= S_SYNC;
                            total_reg <= ticks6(`SYNC_TOTAL_TICKS);
                            frame_angle_reg <= angle;
                            crc_reg <= 4'h5;
                        end
                    end
                    default: begin
                        state_reg <= S_SYNC;
                        total_reg <= ticks6(`SYNC_TOTAL_TICKS);
                        frame_angle_reg <= angle;
                        crc_reg <= 4'h5;
                    end
                endcase
            end
        end
    end
endmodule // sent_frame_tx

/* File: sent_frame_tx_chk.sv */
`timescale 1ns/10ps
module sent_frame_tx_chk #(
    parameter LOGIC_TEST_CYCLES = 20,
    parameter RING_STEPS = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [23:0] reg_rdata,
    // monitors and outputs
    input wire logic supply_low,
    input wire logic [11:0] ring_angle,
    input wire logic sent_out,
    input wire logic error_flag,
    input wire logic [2:0] spi_status,
    input wire logic turn_step_45,
    input wire logic ring_busy,
    input wire logic [5:0] ring_contact,
    input wire logic ring_store,
    input wire logic [11:0] ring_store_angle
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic tc_reg;
    logic [2:0] since_clr;
    logic [5:0] st_cnt;
    ////////////////////////////////////////////////////////////////////////
    // shadow of turn step, age of last control or mask write, stores per run
    always @(posedge mclk) begin
        if (!rstn) begin
            tc_reg <= 1'b0;
            since_clr <= 3'h7;
            st_cnt <= 6'h00;
        end else begin
            if (reg_wr && reg_addr == 8'h15) tc_reg <= reg_wdata[18];
            if (reg_wr && (reg_addr == 8'h08 || reg_addr == 8'h1e)) since_clr <= 3'h0;
            else if (since_clr != 3'h7) since_clr <= since_clr + 3'h1;
            if ($rose(ring_busy)) st_cnt <= {5'h00, ring_store};
            else if (ring_store) st_cnt <= st_cnt + 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // a pulse low interval is never shorter than five ticks of one cycle
    a_low_min: assert property ($fell(sent_out) |-> !sent_out [*5]) else $error("low interval short");
    a_err_fall: assert property ($fell(error_flag) |-> since_clr < 3'h4) else $error("error flag dropped");
    a_rd_unmapped: assert property (reg_rd && !(reg_addr inside {8'h04, 8'h05, 8'h08, [8'h15:8'h19], 8'h1e, 8'h1f})
        |=> reg_rdata == 24'h000000) else $error("unmapped read not zero");
    a_turn_step: assert property (!reg_wr [*3] |-> turn_step_45 == tc_reg) else $error("turn step mismatch");
    a_supply_low: assert property ($stable(supply_low) [*6] |-> spi_status[2] == supply_low) else $error("low flag");
    a_ring_start: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[1] |-> ##[1:2] ring_busy)
        else $error("ring test not started");
    a_ring_contact: assert property (ring_busy |-> ring_contact < 6'(RING_STEPS)) else $error("contact range");
    a_ring_count: assert property ($fell(ring_busy) |-> ##2 st_cnt == 6'(RING_STEPS)) else $error("step count");
    a_store_angle: assert property (ring_store |-> ring_store_angle == ring_angle) else $error("stored angle");
    // main scenarios reached
    c_ring_done: cover property ($fell(ring_busy));
    c_err_clear: cover property ($fell(error_flag));
    c_low_flag: cover property ($rose(spi_status[2]));
endmodule // sent_frame_tx_chk
bind sent_frame_tx sent_frame_tx_chk #(.LOGIC_TEST_CYCLES(LOGIC_TEST_CYCLES), .RING_STEPS(RING_STEPS)) chk (
    .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_low, .ring_angle, .sent_out,
    .error_flag, .spi_status, .turn_step_45, .ring_busy, .ring_contact, .ring_store, .ring_store_angle
);

/* File: sent_rx_model.sv */
`timescale 1ns/10ps
module sent_rx_model (
    // line and setup
    input wire logic mclk,
    input wire logic sent_out,
    input wire logic [5:0] tick,
    input wire logic en,
    // decoded frame
    output logic [3:0] stat_nib,
    output logic [11:0] data_word,
    output logic [3:0] crc_nib,
    output int nib_count,
    output int frames,
    output int low_bad
);
    int cnt = 0;
    int low = 0;
    int idx = 0;
    int len;
    logic prev = 1'b1;
    logic [3:0] nib [0:6];
    ////////////////////////////////////////////////////////////////////////
    // falling edge to falling edge is one pulse; a 56 tick pulse is sync
    always @(posedge mclk) begin
        prev <= sent_out;
        cnt <= cnt + 1;
        low <= sent_out ? 0 : low + 1;
        if (prev && !sent_out) begin
            len = cnt / tick;
            cnt <= 1;
            if (len == 56) begin
                if (idx >= 5) begin
                    stat_nib <= nib[0];
                    data_word <= {nib[1], nib[2], nib[3]};
                    crc_nib <= nib[4];
                    nib_count <= idx;
                    frames <= frames + 1;
                end
                idx <= 0;
            end else if (idx < 7) begin
                nib[idx] <= 4'(len - 12);
                idx <= idx + 1;
            end
        end
        // counts a delimiter that is not five ticks long
        if (en && !prev && sent_out && low != 5 * tick) low_bad <= low_bad + 1;
    end
endmodule // sent_rx_model

/* File: sent_frame_tx_with_diagnostics_tb_top.sv */
`timescale 1ns/10ps
`include "nibble_tx_consts.vh"
module sent_frame_tx_with_diagnostics_tb_top;
    logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, supply_low = 1'b0, en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic [11:0] angle = 12'h000, ring_angle = 12'h000;
    logic [3:0] serial_bits = 4'h0;
    logic [8:0] flt = 9'h000;
    logic [5:0] tick = 6'd2;
    wire [23:0] reg_rdata;
    wire [2:0] spi_status;
    wire [5:0] ring_contact;
    wire [11:0] ring_store_angle, data_word;
    wire [3:0] stat_nib, crc_nib;
    wire sent_out, error_flag, turn_step_45, ring_busy, ring_store;
    int nib_count, frames, low_bad, num_checks = 0, n_mismatch = 0, n;
    logic [7:0] cfg_a [5] = '{8'h15, 8'h16, 8'h18, 8'h19, 8'h1f};
    int fb [6] = '{0, 1, 2, 4, 5, 6};
    sent_frame_tx #(.LOGIC_TEST_CYCLES(20), .RING_STEPS(4)) dut (
        .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .angle, .serial_bits,
        .supply_lost(flt[0]), .field_weak(flt[1]), .logic_fault(flt[2]), .temp_bad(flt[4]),
        .mem_err_single(flt[5]), .mem_err_double(flt[6]), .ring_test_bad(flt[7]), .logic_test_bad(flt[8]),
        .supply_low, .ring_angle, .sent_out, .error_flag, .spi_status, .turn_step_45, .ring_busy,
        .ring_contact, .ring_store, .ring_store_angle
    );
    sent_rx_model rx (.mclk, .sent_out, .tick, .en, .stat_nib, .data_word, .crc_nib, .nib_count, .frames, .low_bad);
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one write: strobe held over one sampling edge
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    // read data holds until the next read, so it is safe at the second edge
    task automatic rc(input logic [7:0] a, input logic [23:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        check(reg_rdata, e);
    endtask
    function automatic logic [3:0] crc4(input logic [11:0] d);
        logic [3:0] c;
        c = 4'h5;
        for (int i = 11; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'hd : 4'h0);
        return c;
    endfunction
    // skip the frame in flight so the one judged is wholly new
    task automatic frame_chk(input logic [3:0] st, input logic [11:0] a, input int cnt);
        int f;
        f = frames;
        for (int k = 0; k < 3000 && frames < f + 2; k++) @(posedge mclk);
        check(24'(frames >= f + 2), 24'h1);
        check(stat_nib, st);
        check(data_word, a);
        check(crc_nib, crc4(a));
        check(24'(nib_count), 24'(cnt));
        check(24'(low_bad), 24'h0);
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rc(`REG_FAULT, 24'h000001);
        rc(8'h30, 24'h0);
        for (int i = 0; i < 5; i++) begin
            rc(cfg_a[i], `CFG_RESET);
            wr(cfg_a[i], 24'h5c3a96 + i);
            rc(cfg_a[i], 24'h5c3a96 + i);
        end
        check(turn_step_45, 1'b1);
        angle <= 12'ha5c;
        wr(`REG_NIBBLE_LINK_CONFIG, 24'h100040);
        repeat (500) @(posedge mclk);
        en <= 1'b1;
        frame_chk(4'h1, 12'ha5c, 6);
        angle <= 12'hfff;
        serial_bits <= 4'h9;
        wr(`REG_NIBBLE_LINK_CONFIG, 24'h200040);
        frame_chk(4'h9, 12'hfff, 5);
        wr(`REG_LOW_POWER_CONFIG_A, 24'h0);
        repeat (2) @(posedge mclk);
        check(turn_step_45, 1'b0);
        // each fault stays recorded after its cause has gone
        for (int i = 0; i < 6; i++) begin
            wr(`REG_CONTROL, 24'h1);
            rc(`REG_FAULT, 24'h0);
            flt[fb[i]] <= 1'b1;
            repeat (6) @(posedge mclk);
            flt[fb[i]] <= 1'b0;
            repeat (6) @(posedge mclk);
            rc(`REG_FAULT, 24'h1 << fb[i]);
            check(error_flag, 1'b1);
        end
        wr(`REG_CONTROL, 24'h1);
        wr(`REG_FAULT_MASK_CONFIG, 24'h2);
        flt[1] <= 1'b1;
        repeat (8) @(posedge mclk);
        rc(`REG_FAULT, 24'h2);
        check(error_flag, 1'b0);
        wr(`REG_FAULT_MASK_CONFIG, 24'h0);
        repeat (2) @(posedge mclk);
        check(error_flag, 1'b1);
        flt[1] <= 1'b0;
        supply_low <= 1'b1;
        repeat (8) @(posedge mclk);
        check(spi_status, 3'b100);
        supply_low <= 1'b0;
        wr(`REG_CONTROL, 24'h1);
        repeat (6) @(posedge mclk);
        check(spi_status, 3'b000);
        // passing and failing runs of both self-tests
        for (int b = 0; b < 2; b++) begin
            flt[8] <= b[0];
            wr(`REG_CONTROL, 24'h4);
            rc(`REG_CONTROL, 24'h4);
            repeat (30) @(posedge mclk);
            rc(`REG_CONTROL, 24'h0);
            rc(`REG_SECOND_FAULT, b ? 24'h10 : 24'h0);
            wr(`REG_CONTROL, 24'h1);
            flt[7] <= b[0];
            ring_angle <= 12'h3c7 + 12'(b);
            wr(`REG_CONTROL, 24'h2);
            check(ring_busy, 1'b1);
            n = 0;
            repeat (300) begin
                @(negedge mclk);
                if (ring_store === 1'b1) n++;
            end
            @(posedge mclk);
            check(24'(n), 24'd4);
            check(ring_store_angle, 12'h3c7 + 12'(b));
            rc(`REG_SECOND_FAULT, b ? 24'h8 : 24'h0);
            wr(`REG_CONTROL, 24'h1);
        end
        results();
    end
endmodule // sent_frame_tx_with_diagnostics_tb_top
